/* core/bit_sync.sv */
`timescale 1ns/100ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // Two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* core/eeprom_pkg.sv */
package eeprom_pkg;

    // Array organisation
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;
    localparam int ADDR_W_SMALL = 6;
    localparam int WORDS_LARGE = 256;
    localparam int WORDS_SMALL = 64;
    localparam int OPCODE_BITS = 2;
    localparam int CNT_W = 5;

    // Opcodes, start flag and extended sub-codes (address top two bits)
    localparam logic START_FLAG = 1'b1;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EXT_DISABLE = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_ENABLE = 2'h3;

    // Data values and reset values
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic DUMMY_BIT = 1'b0;
    localparam logic STATUS_READY = 1'b1;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int WRITE_TIME_NS = 10_000_000;
    localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int DESELECT_MIN_NS = 250;
    localparam int DESELECT_MIN_MIL_NS = 500;
    localparam int TIMER_W = 18;

    typedef enum logic [5:0] {
        L_START = 6'h01,
        L_OP = 6'h02,
        L_ADDR = 6'h04,
        L_DATA = 6'h08,
        L_READ = 6'h10,
        L_DONE = 6'h20
    } link_state_t;

    typedef enum logic [2:0] {
        P_IDLE = 3'h1,
        P_ARMED = 3'h2,
        P_PROG = 3'h4
    } prog_state_t;

endpackage

/* core/serial_eeprom_command_port.sv */
`timescale 1ns/100ps
module serial_eeprom_command_port #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic serial_clock_in,
    input wire logic select_line,
    input wire logic serial_input,
    output logic serial_output,
    output logic serial_output_oe
);
    localparam logic [eeprom_pkg::TIMER_W-1:0] TIMER_LOAD =
        eeprom_pkg::TIMER_W'(WRITE_CYCLES);
    localparam logic [eeprom_pkg::CNT_W-1:0] ADDR_LAST = LARGE_VARIANT ?
        eeprom_pkg::CNT_W'(eeprom_pkg::ADDR_W - 1) :
        eeprom_pkg::CNT_W'(eeprom_pkg::ADDR_W_SMALL - 1);
    localparam logic [eeprom_pkg::CNT_W-1:0] OP_LAST =
        eeprom_pkg::CNT_W'(eeprom_pkg::OPCODE_BITS - 1);
    localparam logic [eeprom_pkg::CNT_W-1:0] DATA_LAST =
        eeprom_pkg::CNT_W'(eeprom_pkg::WORD_W - 1);
    localparam logic [eeprom_pkg::CNT_W-1:0] READ_END =
        eeprom_pkg::CNT_W'(eeprom_pkg::WORD_W);
    localparam logic [8:0] BULK_COUNT = LARGE_VARIANT ?
        9'(eeprom_pkg::WORDS_LARGE) : 9'(eeprom_pkg::WORDS_SMALL);

    // Drop the unused top address bits on the small variant
    function automatic logic [7:0] mask_addr(input logic [7:0] a);
        mask_addr = LARGE_VARIANT ? a : {2'h0, a[5:0]};
    endfunction

    // Sub-code of an extended instruction sits in the address top bits
    function automatic logic [1:0] top_bits(input logic [7:0] a);
        top_bits = LARGE_VARIANT ? a[7:6] : a[5:4];
    endfunction

    // Erase, write, erase-all and write-all all need the enable
    function automatic logic is_prog(input logic [1:0] op,
                                     input logic [7:0] a);
        logic [1:0] t;
        t = top_bits(a);
        is_prog = (op == eeprom_pkg::OP_ERASE) ||
                  (op == eeprom_pkg::OP_WRITE) ||
                  ((op == eeprom_pkg::OP_EXT) &&
                   ((t == eeprom_pkg::EXT_ERASE_ALL) ||
                    (t == eeprom_pkg::EXT_WRITE_ALL)));
    endfunction

    // ---------------- Link domain (serial_clock_in) ----------------
    logic link_rst_n;
    eeprom_pkg::link_state_t lstate_q;
    logic [eeprom_pkg::CNT_W-1:0] cnt_q;
    logic [1:0] op_q;
    logic [7:0] addr_sr_q;
    logic [15:0] data_sr_q;
    logic [15:0] rd_sr_q;
    logic in_instr_q;
    logic rd_active_q;
    logic out_bit_q;
    logic [1:0] cmd_op_q;
    logic [7:0] cmd_addr_q;
    logic [15:0] cmd_data_q;
    logic cmd_tgl_q;
    logic [7:0] rd_addr_q;
    logic rd_tgl_q;
    logic [7:0] addr_full;
    logic addr_done;
    logic needs_data;
    logic [15:0] rd_word_q;

    // Deselect clears the decoder at once, with no clock needed
    assign link_rst_n = nrst & select_line;
    assign addr_full = mask_addr({addr_sr_q[6:0], serial_input});
    assign addr_done = (lstate_q == eeprom_pkg::L_ADDR) &&
                       (cnt_q == ADDR_LAST);
    assign needs_data = (op_q == eeprom_pkg::OP_WRITE) ||
                        ((op_q == eeprom_pkg::OP_EXT) &&
                         (top_bits(addr_full) ==
                          eeprom_pkg::EXT_WRITE_ALL));

    // Instruction decoder, bits taken on rising serial clock
    always_ff @(posedge serial_clock_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lstate_q <= eeprom_pkg::L_START;
            cnt_q <= '0;
            op_q <= eeprom_pkg::OP_EXT;
            addr_sr_q <= eeprom_pkg::ADDR_RST;
            data_sr_q <= eeprom_pkg::WORD_RST;
            rd_sr_q <= eeprom_pkg::WORD_RST;
            in_instr_q <= 1'b0;
            rd_active_q <= 1'b0;
            out_bit_q <= eeprom_pkg::DUMMY_BIT;
        end else begin
            case (lstate_q)
                eeprom_pkg::L_START: begin
                    // Leading zeros before the start flag are skipped
                    if (serial_input == eeprom_pkg::START_FLAG) begin
                        in_instr_q <= 1'b1;
                        cnt_q <= '0;
                        lstate_q <= eeprom_pkg::L_OP;
                    end
                end
                eeprom_pkg::L_OP: begin
                    op_q <= {op_q[0], serial_input};
                    if (cnt_q == OP_LAST) begin
                        cnt_q <= '0;
                        lstate_q <= eeprom_pkg::L_ADDR;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                eeprom_pkg::L_ADDR: begin
                    addr_sr_q <= {addr_sr_q[6:0], serial_input};
                    if (addr_done) begin
                        cnt_q <= '0;
                        if (op_q == eeprom_pkg::OP_READ) begin
                            rd_active_q <= 1'b1;
                            out_bit_q <= eeprom_pkg::DUMMY_BIT;
                            lstate_q <= eeprom_pkg::L_READ;
                        end else if (needs_data) begin
                            lstate_q <= eeprom_pkg::L_DATA;
                        end else begin
                            lstate_q <= eeprom_pkg::L_DONE;
                        end
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                eeprom_pkg::L_DATA: begin
                    data_sr_q <= {data_sr_q[14:0], serial_input};
                    if (cnt_q == DATA_LAST) begin
                        lstate_q <= eeprom_pkg::L_DONE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                eeprom_pkg::L_READ: begin
                    // First edge after the dummy loads the fetched word
                    if (cnt_q == '0) begin
                        out_bit_q <= rd_word_q[15];
                        rd_sr_q <= {rd_word_q[14:0], 1'b0};
                    end else begin
                        out_bit_q <= rd_sr_q[15];
                        rd_sr_q <= {rd_sr_q[14:0], 1'b0};
                    end
                    if (cnt_q == READ_END) begin
                        rd_active_q <= 1'b0;
                        lstate_q <= eeprom_pkg::L_DONE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                eeprom_pkg::L_DONE: begin
                    lstate_q <= eeprom_pkg::L_DONE;
                end
                default: begin
                    lstate_q <= eeprom_pkg::L_START;
                end
            endcase
        end
    end

    // Finished commands; held across deselect for the core to pick up
    always_ff @(posedge serial_clock_in or negedge nrst) begin
        if (!nrst) begin
            cmd_op_q <= eeprom_pkg::OP_EXT;
            cmd_addr_q <= eeprom_pkg::ADDR_RST;
            cmd_data_q <= eeprom_pkg::WORD_RST;
            cmd_tgl_q <= 1'b0;
            rd_addr_q <= eeprom_pkg::ADDR_RST;
            rd_tgl_q <= 1'b0;
        end else if (select_line) begin
            if (addr_done && (op_q == eeprom_pkg::OP_READ)) begin
                rd_addr_q <= addr_full;
                rd_tgl_q <= ~rd_tgl_q;
            end else if (addr_done && !needs_data) begin
                cmd_op_q <= op_q;
                cmd_addr_q <= addr_full;
                cmd_tgl_q <= ~cmd_tgl_q;
            end else if (lstate_q == eeprom_pkg::L_DATA &&
                         cnt_q == DATA_LAST) begin
                cmd_op_q <= op_q;
                cmd_addr_q <= mask_addr(addr_sr_q);
                cmd_data_q <= {data_sr_q[14:0], serial_input};
                cmd_tgl_q <= ~cmd_tgl_q;
            end
        end
    end

    // ---------------- Core domain (core_clk) ----------------
    logic [5:0] sync_q;
    logic sel_s;
    logic cmd_s;
    logic rd_s;
    logic instr_s;
    logic ract_s;
    logic rbit_s;
    logic cmd_seen_q;
    logic rd_seen_q;
    logic cmd_evt;
    logic rd_evt;
    logic enable_q;
    eeprom_pkg::prog_state_t pstate_q;
    logic p_bulk_q;
    logic [7:0] p_addr_q;
    logic [15:0] p_wdata_q;
    logic [8:0] idx_q;
    logic [eeprom_pkg::TIMER_W-1:0] timer_q;
    logic show_status_q;
    logic [1:0] fetch_q;
    logic [7:0] fetch_addr_q;
    logic [15:0] mem_rdata;
    logic mem_we;
    logic [7:0] mem_waddr;
    logic [1:0] cmd_top;

    bit_sync #(
        .WIDTH(6)
    ) u_sync (
        .clk(core_clk),
        .rst_n(nrst),
        .d({select_line, cmd_tgl_q, rd_tgl_q, in_instr_q, rd_active_q,
            out_bit_q}),
        .q(sync_q)
    );

    assign {sel_s, cmd_s, rd_s, instr_s, ract_s, rbit_s} = sync_q;
    assign cmd_evt = cmd_s ^ cmd_seen_q;
    assign rd_evt = rd_s ^ rd_seen_q;
    assign cmd_top = top_bits(cmd_addr_q);

    // Toggle edge detection on the synchronised copies
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_seen_q <= 1'b0;
            rd_seen_q <= 1'b0;
        end else begin
            cmd_seen_q <= cmd_s;
            rd_seen_q <= rd_s;
        end
    end

    // Programming enable; only the enable and disable commands move it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= 1'b0;
        end else if (cmd_evt && cmd_op_q == eeprom_pkg::OP_EXT) begin
            if (cmd_top == eeprom_pkg::EXT_ENABLE) begin
                enable_q <= 1'b1;
            end else if (cmd_top == eeprom_pkg::EXT_DISABLE) begin
                enable_q <= 1'b0;
            end
        end
    end

    // Read fetch: the word is settled long before the next serial edge,
    // since one serial period spans at least twenty core cycles
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fetch_q <= 2'h0;
            fetch_addr_q <= eeprom_pkg::ADDR_RST;
            rd_word_q <= eeprom_pkg::WORD_RST;
        end else begin
            fetch_q <= {fetch_q[0], rd_evt};
            if (rd_evt) begin
                fetch_addr_q <= rd_addr_q;
            end
            if (fetch_q[1]) begin
                rd_word_q <= mem_rdata;
            end
        end
    end

    // Self-timed programming sequencer
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pstate_q <= eeprom_pkg::P_IDLE;
            p_bulk_q <= 1'b0;
            p_addr_q <= eeprom_pkg::ADDR_RST;
            p_wdata_q <= eeprom_pkg::WORD_RST;
            idx_q <= 9'h000;
            timer_q <= '0;
        end else begin
            case (pstate_q)
                eeprom_pkg::P_IDLE,
                eeprom_pkg::P_ARMED: begin
                    if (cmd_evt) begin
                        // Disabled device leaves the array untouched
                        if (enable_q && is_prog(cmd_op_q, cmd_addr_q)) begin
                            pstate_q <= eeprom_pkg::P_ARMED;
                            p_bulk_q <= (cmd_op_q == eeprom_pkg::OP_EXT);
                            p_addr_q <= cmd_addr_q;
                            if (cmd_op_q == eeprom_pkg::OP_ERASE ||
                                cmd_op_q == eeprom_pkg::OP_EXT &&
                                cmd_top == eeprom_pkg::EXT_ERASE_ALL) begin
                                p_wdata_q <= eeprom_pkg::ERASED_WORD;
                            end else begin
                                p_wdata_q <= cmd_data_q;
                            end
                        end else begin
                            pstate_q <= eeprom_pkg::P_IDLE;
                        end
                    end else if (pstate_q == eeprom_pkg::P_ARMED &&
                                 !sel_s) begin
                        pstate_q <= eeprom_pkg::P_PROG;
                        idx_q <= 9'h000;
                        timer_q <= TIMER_LOAD;
                    end
                end
                eeprom_pkg::P_PROG: begin
                    if (mem_we) begin
                        idx_q <= idx_q + 1'b1;
                    end
                    if (timer_q <= 1) begin
                        pstate_q <= eeprom_pkg::P_IDLE;
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                default: begin
                    pstate_q <= eeprom_pkg::P_IDLE;
                end
            endcase
        end
    end

    // Bulk operations walk the array one word per cycle
    assign mem_we = (pstate_q == eeprom_pkg::P_PROG) &&
                    (idx_q < (p_bulk_q ? BULK_COUNT : 9'h001));
    assign mem_waddr = p_bulk_q ? idx_q[7:0] : p_addr_q;

    word_array u_array (
        .clk(core_clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(p_wdata_q),
        .raddr(fetch_addr_q),
        .rdata(mem_rdata)
    );

    // Status shows from programming start until the next start flag
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            show_status_q <= 1'b0;
        end else if (pstate_q == eeprom_pkg::P_ARMED && !sel_s) begin
            show_status_q <= 1'b1;
        end else if (instr_s) begin
            show_status_q <= 1'b0;
        end
    end

    // Output pin; read data wins over status, deselect floats the pin
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            serial_output <= 1'b0;
            serial_output_oe <= 1'b0;
        end else if (!sel_s) begin
            serial_output <= 1'b0;
            serial_output_oe <= 1'b0;
        end else if (ract_s) begin
            serial_output <= rbit_s;
            serial_output_oe <= 1'b1;
        end else if (show_status_q) begin
            serial_output <= (pstate_q == eeprom_pkg::P_PROG) ?
                ~eeprom_pkg::STATUS_READY : eeprom_pkg::STATUS_READY;
            serial_output_oe <= 1'b1;
        end else begin
            serial_output <= 1'b0;
            serial_output_oe <= 1'b0;
        end
    end
endmodule

/* core/word_array.sv */
`timescale 1ns/100ps
module word_array (
    input wire logic clk,
    input wire logic we,
    input wire logic [eeprom_pkg::ADDR_W-1:0] waddr,
    input wire logic [eeprom_pkg::WORD_W-1:0] wdata,
    input wire logic [eeprom_pkg::ADDR_W-1:0] raddr,
    output logic [eeprom_pkg::WORD_W-1:0] rdata
);
    logic [eeprom_pkg::WORD_W-1:0] mem_q [0:eeprom_pkg::WORDS_LARGE-1];

    // Contents have no reset, as a non-volatile array would not
    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk) begin
        rdata <= mem_q[raddr];
    end
endmodule

/* tb/eeprom_link_asserts.sv */
`timescale 1ns/100ps
module eeprom_link_asserts (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic serial_clock_in,
    input wire logic select_line,
    input wire logic serial_input,
    input wire logic serial_output,
    input wire logic serial_output_oe
);
    logic sk_q;
    logic sel_q;
    logic [3:0] sk_age_q;
    logic [3:0] sel_age_q;
    logic [3:0] low_q;

    // Ages of link events, saturating so long idles read as large
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sk_q <= 1'b0;
            sel_q <= 1'b0;
            sk_age_q <= 4'hf;
            sel_age_q <= 4'hf;
            low_q <= 4'h0;
        end else begin
            sk_q <= serial_clock_in;
            sel_q <= select_line;
            sk_age_q <= (serial_clock_in && !sk_q) ? 4'h0 :
                sk_age_q + {3'h0, sk_age_q != 4'hf};
            sel_age_q <= (select_line && !sel_q) ? 4'h0 :
                sel_age_q + {3'h0, sel_age_q != 4'hf};
            low_q <= select_line ? 4'h0 : low_q + {3'h0, low_q != 4'hf};
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_reset_quiet: assert property ($rose(nrst) |->
        !serial_output_oe && !serial_output) else $error("busy pin after reset");
    a_float_low: assert property (low_q >= 4'h5 |->
        !serial_output_oe) else $error("output driven while deselected");
    a_stay_float: assert property (!select_line && !serial_output_oe
        |=> !serial_output_oe) else $error("output woke while deselected");
    a_oe_on_sel: assert property ($rose(serial_output_oe)
        |-> select_line) else $error("output enabled without select");
    a_oe_cause: assert property ($rose(serial_output_oe) |->
        sk_age_q <= 4'h5 || sel_age_q <= 4'h5) else $error("stray enable");
    a_dummy_low: assert property ($rose(serial_output_oe) &&
        sel_age_q > 4'h5 |-> !serial_output) else $error("dummy bit not 0");
    a_oe_release: assert property ($fell(serial_output_oe) |->
        sk_age_q <= 4'h6 || (low_q >= 4'h1 && low_q <= 4'h6))
        else $error("output released without cause");
    a_one_holds: assert property (serial_output_oe && serial_output &&
        select_line && sk_age_q > 4'h6 |=> serial_output || !serial_output_oe)
        else $error("output fell without serial edge");

    c_read_dummy: cover property ($rose(serial_output_oe) && !serial_output);
    c_ready: cover property (serial_output_oe && $rose(serial_output));
    c_float: cover property ($fell(serial_output_oe) && !select_line);
endmodule

bind serial_eeprom_command_port eeprom_link_asserts eeprom_link_asserts_inst (
    .core_clk, .nrst, .serial_clock_in, .select_line, .serial_input,
    .serial_output, .serial_output_oe);

/* tb/host_link_model.sv */
`timescale 1ns/100ps
module host_link_model (
    output logic select_line,
    output logic serial_clock_in,
    output logic serial_input,
    input wire logic pin_do
);
    logic link_clk = 1'b0;

    // 48 ns base; the serial clock itself only moves inside frames
    always #24 link_clk = ~link_clk;

    initial begin
        select_line = 1'b0;
        serial_clock_in = 1'b0;
        serial_input = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge link_clk);
    endtask

    // Released data line shows the inverse, never a stale value
    task automatic deselect();
        select_line = 1'b0;
        serial_input = ~serial_input;
        ticks(22);
    endtask

    // n rises, bits MSB first; pin sampled just before every rise
    task automatic frame(input logic [27:0] b, input int n,
                         output logic [16:0] cap);
        cap = 17'h0_0000;
        select_line = 1'b1;
        ticks(13);
        for (int i = n - 1; i >= 0; i--) begin
            serial_input = b[i];
            ticks(13);
            cap = {cap[15:0], pin_do};
            serial_clock_in = 1'b1;
            ticks(13);
            serial_clock_in = 1'b0;
        end
        ticks(13);
        deselect();
    endtask

    // Poll status until ready, bounded so a stuck busy cannot hang
    task automatic status(output logic first, output int polls);
        select_line = 1'b1;
        ticks(5);
        first = pin_do;
        polls = 0;
        while (pin_do !== 1'b1 && polls < 1000) begin
            ticks(1);
            polls++;
        end
        deselect();
    endtask
endmodule

/* tb/serial_eeprom_command_port_test.sv */
`timescale 1ns/100ps
module serial_eeprom_command_port_test;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic sk, sel, din, dout, oe;
    wire pin_do;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    logic [16:0] cap;
    logic first;
    int polls;

    // Pin floats when the device lets go
    assign pin_do = oe ? dout : 1'bz;

    always #25 core_clk = ~core_clk;

    serial_eeprom_command_port #(.WRITE_CYCLES(300), .LARGE_VARIANT(1'b1))
        serial_eeprom_command_port_inst (.core_clk(core_clk), .nrst(nrst),
        .serial_clock_in(sk), .select_line(sel), .serial_input(din),
        .serial_output(dout), .serial_output_oe(oe));

    host_link_model host_link_model_inst (.select_line(sel),
        .serial_clock_in(sk), .serial_input(din), .pin_do(pin_do));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the roughly 20k cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            fails++;
            end_sim();
        end
    end

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [27:0] fr(logic [1:0] op, logic [7:0] a,
                                       logic [15:0] d, int n);
        return {1'b0, 1'b1, op, a, d} >> (27 - n);
    endfunction

    // Extended command; the don't-care address bits are not all zero
    task automatic ext(input logic [1:0] top);
        host_link_model_inst.frame(fr(2'h0, {top, 6'h2a}, 16'h0000, 11),
            11, cap);
    endtask

    // Disabled: pin stays floating. Enabled: busy, then ready in time
    task automatic prog(input logic [1:0] op, input logic [7:0] a,
                        input logic [15:0] d, input int n, input logic on);
        host_link_model_inst.frame(fr(op, a, d, n), n, cap);
        host_link_model_inst.status(first, polls);
        chk({16'h0000, first}, on ? 17'h0_0000 : {16'h0000, 1'bz});
        if (on)
            chk({16'h0000, polls > 250 && polls < 330}, 17'h0_0001);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        host_link_model_inst.frame({1'b1, 2'h2, a, 17'h0_0000}, 28, cap);
        chk(cap, {1'b0, exp});
    endtask

    task automatic t_power_up();
        prog(2'h1, 8'h05, 16'h1234, 27, 1'b0);
        $display("power-up test done");
    endtask

    task automatic t_write_read();
        ext(2'h3);
        prog(2'h1, 8'ha5, 16'h8001, 27, 1'b1);
        prog(2'h1, 8'h5a, 16'h7ffe, 27, 1'b1);
        rd(8'ha5, 16'h8001);
        rd(8'h5a, 16'h7ffe);
        $display("write and read test done");
    endtask

    task automatic t_bulk();
        prog(2'h0, 8'h6b, 16'hc33c, 27, 1'b1);
        rd(8'h00, 16'hc33c);
        rd(8'hff, 16'hc33c);
        prog(2'h3, 8'h00, 16'h0000, 11, 1'b1);
        rd(8'h00, 16'hffff);
        rd(8'hff, 16'hc33c);
        prog(2'h0, 8'h9c, 16'h0000, 11, 1'b1);
        rd(8'hff, 16'hffff);
        $display("bulk test done");
    endtask

    task automatic t_disable();
        ext(2'h0);
        prog(2'h1, 8'h10, 16'h1234, 27, 1'b0);
        prog(2'h0, 8'h55, 16'h0000, 27, 1'b0);
        rd(8'h10, 16'hffff);
        ext(2'h3);
        rd(8'h33, 16'hffff);
        prog(2'h1, 8'h10, 16'h1234, 27, 1'b1);
        rd(8'h10, 16'h1234);
        $display("disable test done");
    endtask

    // Read cut short in its address; decoder must start afresh
    task automatic t_abort();
        host_link_model_inst.frame({22'h00_0000, 1'b1, 2'h2, 3'h5}, 6, cap);
        chk({16'h0000, pin_do}, {16'h0000, 1'bz});
        rd(8'h10, 16'h1234);
        $display("abort test done");
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        t_power_up();
        t_write_read();
        t_bulk();
        t_disable();
        t_abort();
        end_sim();
    end
endmodule
